// ### rtl/sync_serial_pkg.sv
// Constants shared by the synchronous serial shift port.
// Assumes a 32-bit APB master that presents full byte addresses.
package sync_serial_pkg;
   localparam logic [31:0] ADDR_CONTROL = 32'h01d14000;
   localparam logic [31:0] ADDR_DATA = 32'h01d14004;
   localparam logic [31:0] ADDR_PRESCALER = 32'h01d14008;
   localparam logic [31:0] ADDR_GAP = 32'h01d1400c;
   localparam logic [31:0] ADDR_GATE = 32'h01d14010;
   localparam logic [31:0] ADDR_INT_STATUS = 32'h01d14014;
   localparam logic [31:0] ADDR_INT_ENABLE = 32'h01d14018;
   localparam logic [31:0] ADDR_INT_CLEAR = 32'h01d1401c;
   localparam int CTL_EXT_CLK = 7;
   localparam int CTL_LSB_FIRST = 6;
   localparam int CTL_TX_RX = 5;
   localparam int CTL_RISE_EDGE = 4;
   localparam int CTL_START = 3;
   localparam int CTL_SHIFT_OP = 2;
   localparam int CTL_MODE_HI = 1;
   localparam int INT_DONE = 0;
   localparam int INT_DMA_REQ = 1;
   localparam int BITS_PER_BYTE = 8;
   localparam int GAP_UNIT = 4;
   localparam logic [1:0] MODE_NONE = 2'h0;
   localparam logic [1:0] MODE_INTR = 2'h1;
   localparam logic [1:0] MODE_DMA0 = 2'h2;
   localparam logic [1:0] MODE_DMA1 = 2'h3;
   localparam logic [7:0] CONTROL_RESET = 8'h00;
   localparam logic [7:0] DATA_RESET = 8'h00;
   localparam logic [1:0] GATE_RESET = 2'h0;
   localparam logic [1:0] INT_RESET = 2'h0;
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_SHIFT = 2'b01,
      ST_GAP = 2'b10
   } shift_state_t;
endpackage : sync_serial_pkg

// ### rtl/sync_serial_port.sv
// Byte-wide synchronous serial shift port with APB registers, DMA request
// gating and a level interrupt.
// Assumes pins are synchronous to pclk and a remote device on the serial link.
//
// Added by the designer: the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module sync_serial_port #(
   parameter int PRESC_W = 12,
   parameter int GAP_W = 8
) (
   input wire logic pclk, // System clock.
   input wire logic presetn, // Asynchronous reset, active low.
   input wire logic psel, // APB select.
   input wire logic penable, // APB access phase.
   input wire logic pwrite, // APB write when high.
   input wire logic [31:0] paddr, // APB byte address.
   input wire logic [31:0] pwdata, // APB write data.
   output logic [31:0] prdata, // APB read data.
   output logic pready, // APB transfer done.
   output logic pslverr, // APB error on unmapped address.
   input wire logic sclk_i, // Shift clock from the remote device.
   output logic sclk_o, // Shift clock driven to the link.
   output logic sclk_oe, // Shift clock output enable.
   output logic sdo, // Serial data out.
   input wire logic sdi, // Serial data in.
   output logic dma_req0, // Service request pulse to DMA channel 0.
   output logic dma_req1, // Service request pulse to DMA channel 1.
   output logic irq // Level interrupt.
);
   initial begin
      if (PRESC_W != 12 || GAP_W != 8) begin
         $error("sync_serial_port: register fields are fixed at 12 and 8 bits");
      end
   end

   sync_serial_pkg::shift_state_t st_q;
   logic [7:0] ctl_q;
   logic [7:0] data_q;
   logic [PRESC_W-1:0] presc_q;
   logic [PRESC_W-1:0] baud_cnt_q;
   logic [GAP_W-1:0] gap_q;
   logic [GAP_W+1:0] gap_cnt_q;
   logic [1:0] gate_q;
   logic [1:0] int_st_q;
   logic [1:0] int_en_q;
   logic [2:0] bit_cnt_q;
   logic ph_q;
   logic sclk_s_q;
   logic pend_q;
   logic start_pulse;
   logic wr_en;
   logic rd_en;
   logic hit;
   logic [31:0] rd_mux;
   logic [1:0] mode;
   logic dma_mode;
   logic gate_ok;
   logic tx_dma;
   logic tick;
   logic launch;
   logic capture;
   logic byte_done;
   logic gap_end;
   logic [GAP_W+1:0] gap_lim;
   logic data_wr;
   logic req_tx;
   logic req_rx;

   assign mode = ctl_q[sync_serial_pkg::CTL_MODE_HI:0];
   assign dma_mode = mode[1];
   assign gate_ok = dma_mode && !gate_q[mode[0]];
   assign tx_dma = dma_mode && ctl_q[sync_serial_pkg::CTL_TX_RX];

   // The bus answers after one wait state so that every bus output is a flop.
   assign wr_en = psel && penable && pready && pwrite;
   assign rd_en = psel && penable && !pready;
   assign data_wr = wr_en && (paddr == sync_serial_pkg::ADDR_DATA);

   always_comb begin
      hit = 1'b1;
      rd_mux = 32'h00000000;
      case (paddr)
         sync_serial_pkg::ADDR_CONTROL: begin
            rd_mux = {24'h000000, ctl_q};
         end
         sync_serial_pkg::ADDR_DATA: begin
            rd_mux = {24'h000000, data_q};
         end
         sync_serial_pkg::ADDR_PRESCALER: begin
            rd_mux = {20'h00000, presc_q};
         end
         sync_serial_pkg::ADDR_GAP: begin
            rd_mux = {24'h000000, gap_q};
         end
         sync_serial_pkg::ADDR_GATE: begin
            rd_mux = {30'h0, gate_q};
         end
         sync_serial_pkg::ADDR_INT_STATUS: begin
            rd_mux = {30'h0, int_st_q};
         end
         sync_serial_pkg::ADDR_INT_ENABLE: begin
            rd_mux = {30'h0, int_en_q};
         end
         sync_serial_pkg::ADDR_INT_CLEAR: begin
            rd_mux = 32'h00000000;
         end
         default: begin
            hit = 1'b0;
         end
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         prdata <= 32'h00000000;
         pslverr <= 1'b0;
      end else begin
         pready <= rd_en;
         prdata <= (rd_en && !pwrite) ? rd_mux : 32'h00000000;
         pslverr <= rd_en && !hit;
      end
   end

   // The start bit never stores; it only produces a one-cycle pulse.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctl_q <= sync_serial_pkg::CONTROL_RESET;
      end else if (wr_en && paddr == sync_serial_pkg::ADDR_CONTROL) begin
         ctl_q <= pwdata[7:0] & ~(8'h01 << sync_serial_pkg::CTL_START);
      end
   end
   assign start_pulse = wr_en && (paddr == sync_serial_pkg::ADDR_CONTROL)
      && pwdata[sync_serial_pkg::CTL_START];

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         presc_q <= '0;
         gap_q <= '0;
         gate_q <= sync_serial_pkg::GATE_RESET;
         int_en_q <= sync_serial_pkg::INT_RESET;
      end else if (wr_en) begin
         if (paddr == sync_serial_pkg::ADDR_PRESCALER) begin
            presc_q <= pwdata[PRESC_W-1:0];
         end
         if (paddr == sync_serial_pkg::ADDR_GAP) begin
            gap_q <= pwdata[GAP_W-1:0];
         end
         if (paddr == sync_serial_pkg::ADDR_GATE) begin
            gate_q <= pwdata[1:0];
         end
         if (paddr == sync_serial_pkg::ADDR_INT_ENABLE) begin
            int_en_q <= pwdata[1:0];
         end
      end
   end

   // Shift clock events: internal divider or edges of the remote clock.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         baud_cnt_q <= '0;
         sclk_s_q <= 1'b1;
      end else begin
         sclk_s_q <= sclk_i;
         if (st_q != sync_serial_pkg::ST_SHIFT || baud_cnt_q == presc_q) begin
            baud_cnt_q <= '0;
         end else begin
            baud_cnt_q <= baud_cnt_q + PRESC_W'(1);
         end
      end
   end
   assign tick = (st_q == sync_serial_pkg::ST_SHIFT) && (ctl_q[sync_serial_pkg::CTL_EXT_CLK]
      ? (sclk_i != sclk_s_q) : (baud_cnt_q == presc_q));
   assign launch = tick && !ph_q;
   assign capture = tick && ph_q;
   assign byte_done = capture && (bit_cnt_q == 3'(sync_serial_pkg::BITS_PER_BYTE - 1));
   assign gap_lim = {gap_q, 2'b11};
   assign gap_end = (st_q == sync_serial_pkg::ST_GAP) && (gap_cnt_q == gap_lim);
   assign req_tx = (st_q == sync_serial_pkg::ST_IDLE) && tx_dma && gate_ok && !pend_q;
   assign req_rx = byte_done && dma_mode && !ctl_q[sync_serial_pkg::CTL_TX_RX] && gate_ok;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_q <= sync_serial_pkg::ST_IDLE;
         bit_cnt_q <= 3'h0;
         ph_q <= 1'b0;
         gap_cnt_q <= '0;
      end else begin
         case (st_q)
            sync_serial_pkg::ST_IDLE: begin
               ph_q <= 1'b0;
               if ((start_pulse && pwdata[1:0] != sync_serial_pkg::MODE_NONE && !(pwdata[1]
                  && pwdata[sync_serial_pkg::CTL_TX_RX])) || (data_wr && pend_q && tx_dma)) begin
                  bit_cnt_q <= 3'h0;
                  st_q <= sync_serial_pkg::ST_SHIFT;
               end
            end
            sync_serial_pkg::ST_SHIFT: begin
               if (tick) begin
                  ph_q <= !ph_q;
               end
               if (capture) begin
                  bit_cnt_q <= bit_cnt_q + 3'h1;
               end
               if (byte_done) begin
                  gap_cnt_q <= '0;
                  st_q <= sync_serial_pkg::ST_GAP;
               end
            end
            sync_serial_pkg::ST_GAP: begin
               gap_cnt_q <= gap_cnt_q + (GAP_W+2)'(1);
               if (gap_end) begin
                  // Receive DMA keeps running byte after byte until the gate closes.
                  if (dma_mode && !tx_dma && gate_ok) begin
                     bit_cnt_q <= 3'h0;
                     ph_q <= 1'b0;
                     st_q <= sync_serial_pkg::ST_SHIFT;
                  end else begin
                     st_q <= sync_serial_pkg::ST_IDLE;
                  end
               end
            end
            default: begin
               st_q <= sync_serial_pkg::ST_IDLE;
            end
         endcase
      end
   end

   // Software writes to the data register are ignored while a byte is in flight.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         data_q <= sync_serial_pkg::DATA_RESET;
      end else if (capture) begin
         if (ctl_q[sync_serial_pkg::CTL_LSB_FIRST]) begin
            data_q <= {sdi, data_q[7:1]};
         end else begin
            data_q <= {data_q[6:0], sdi};
         end
      end else if (data_wr && st_q == sync_serial_pkg::ST_IDLE) begin
         data_q <= pwdata[7:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sdo <= 1'b0;
         sclk_o <= 1'b1;
         sclk_oe <= 1'b0;
      end else begin
         sclk_oe <= !ctl_q[sync_serial_pkg::CTL_EXT_CLK];
         if (launch) begin
            sdo <= ctl_q[sync_serial_pkg::CTL_LSB_FIRST] ? data_q[0] : data_q[7];
            sclk_o <= ctl_q[sync_serial_pkg::CTL_RISE_EDGE];
         end else if (capture || st_q != sync_serial_pkg::ST_SHIFT) begin
            sclk_o <= !ctl_q[sync_serial_pkg::CTL_RISE_EDGE];
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pend_q <= 1'b0;
         dma_req0 <= 1'b0;
         dma_req1 <= 1'b0;
      end else begin
         if (req_tx) begin
            pend_q <= 1'b1;
         end else if (!tx_dma || data_wr) begin
            pend_q <= 1'b0;
         end
         dma_req0 <= (req_tx || req_rx) && (mode == sync_serial_pkg::MODE_DMA0);
         dma_req1 <= (req_tx || req_rx) && (mode == sync_serial_pkg::MODE_DMA1);
      end
   end

   // A new event in the clearing cycle keeps its status bit set.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         int_st_q <= sync_serial_pkg::INT_RESET;
         irq <= 1'b0;
      end else begin
         int_st_q[sync_serial_pkg::INT_DONE] <= (byte_done
            && mode == sync_serial_pkg::MODE_INTR) || (int_st_q[sync_serial_pkg::INT_DONE]
            && !(wr_en && paddr == sync_serial_pkg::ADDR_INT_CLEAR
            && pwdata[sync_serial_pkg::INT_DONE]));
         int_st_q[sync_serial_pkg::INT_DMA_REQ] <= req_tx || req_rx
            || (int_st_q[sync_serial_pkg::INT_DMA_REQ]
            && !(wr_en && paddr == sync_serial_pkg::ADDR_INT_CLEAR
            && pwdata[sync_serial_pkg::INT_DMA_REQ]));
         irq <= |(int_st_q & int_en_q);
      end
   end

   property p_start_shift;
      @(posedge pclk) disable iff (!presetn)
      (start_pulse && st_q == sync_serial_pkg::ST_IDLE && pwdata[1:0] == sync_serial_pkg::MODE_INTR)
      |=> (st_q == sync_serial_pkg::ST_SHIFT && bit_cnt_q == 3'h0
      && !ctl_q[sync_serial_pkg::CTL_START]);
   endproperty
   a_start_shift: assert property (p_start_shift) else $error("start did not begin shift");

   property p_baud_tick;
      @(posedge pclk) disable iff (!presetn)
      (st_q == sync_serial_pkg::ST_SHIFT && !ctl_q[7] && tick)
      |=> (!tick || presc_q == '0) && baud_cnt_q == '0;
   endproperty
   a_baud_tick: assert property (p_baud_tick) else $error("shift clock divider wrong");

   property p_done_flag;
      @(posedge pclk) disable iff (!presetn)
      (byte_done && mode == sync_serial_pkg::MODE_INTR)
      |=> int_st_q[0] && st_q == sync_serial_pkg::ST_GAP ##1 irq == int_en_q[0];
   endproperty
   a_done_flag: assert property (p_done_flag) else $error("completion not flagged");

   property p_gap_len;
      @(posedge pclk) disable iff (!presetn)
      $rose(st_q == sync_serial_pkg::ST_GAP) && gap_q == 8'h01
      |-> (st_q == sync_serial_pkg::ST_GAP) [*8] ##1 (st_q != sync_serial_pkg::ST_GAP);
   endproperty
   a_gap_len: assert property (p_gap_len) else $error("byte gap length wrong");

   property p_gate0;
      @(posedge pclk) disable iff (!presetn)
      dma_req0 |-> !$past(gate_q[0]) && $past(mode) == sync_serial_pkg::MODE_DMA0;
   endproperty
   a_gate0: assert property (p_gate0) else $error("channel 0 request while gated");

   property p_gate1;
      @(posedge pclk) disable iff (!presetn)
      dma_req1 |-> !$past(gate_q[1]) && $past(mode) == sync_serial_pkg::MODE_DMA1;
   endproperty
   a_gate1: assert property (p_gate1) else $error("channel 1 request while gated");

   property p_rx_req;
      @(posedge pclk) disable iff (!presetn)
      (byte_done && mode == sync_serial_pkg::MODE_DMA0 && !ctl_q[5] && !gate_q[0])
      |=> dma_req0 ##1 !dma_req0;
   endproperty
   a_rx_req: assert property (p_rx_req) else $error("no request after received byte");

   property p_capture_order;
      @(posedge pclk) disable iff (!presetn)
      capture |=> (ctl_q[6] ? data_q[7] : data_q[0]) == $past(sdi);
   endproperty
   a_capture_order: assert property (p_capture_order) else $error("capture order wrong");

   property p_launch_bit;
      @(posedge pclk) disable iff (!presetn)
      launch |=> sdo == (ctl_q[6] ? $past(data_q[0]) : $past(data_q[7]));
   endproperty
   a_launch_bit: assert property (p_launch_bit) else $error("launched bit wrong");
endmodule : sync_serial_port
`default_nettype wire

// ### verif/serial_remote_model.sv
// Behavioural remote shift device on the serial link of the shift port.
// Assumes the port idles its shift clock high, so each low phase is one bit slot.
`timescale 1ns/1ps
`default_nettype none
module serial_remote_model (
   input wire logic pclk, // System clock.
   input wire logic presetn, // Asynchronous reset, active low.
   input wire logic sclk, // Shift clock from the port.
   input wire logic sdo, // Data from the port.
   output logic sdi, // Data to the port.
   input wire logic load, // Pulse that restarts the bit index.
   input wire logic [7:0] tx_byte, // Byte sent to the port.
   input wire logic lsb_first, // Bit order for both directions.
   output logic [7:0] rx_q // Byte captured from the port.
);
   logic [2:0] idx_q;
   logic sclk_q;
   logic junk_q;
   // Outside a low phase the line toggles, so a sample at the wrong moment cannot match.
   assign sdi = sclk ? junk_q : tx_byte[lsb_first ? idx_q : 3'h7 - idx_q];
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         idx_q <= 3'h0;
         sclk_q <= 1'b1;
         junk_q <= 1'b0;
         rx_q <= 8'h00;
      end else begin
         junk_q <= ~junk_q;
         sclk_q <= sclk;
         if (load) begin
            idx_q <= 3'h0;
         end else if (sclk && !sclk_q) begin
            idx_q <= idx_q + 3'h1;
            rx_q <= lsb_first ? {sdo, rx_q[7:1]} : {rx_q[6:0], sdo};
         end
      end
   end
endmodule : serial_remote_model
`default_nettype wire

// ### verif/sync_serial_port_tb_top.sv
// Self-checking bench for the shift port: register table, transfers, gap and DMA gating.
// Assumes one APB wait state and the remote model on the serial link.
`timescale 1ns/1ps
`default_nettype none
module sync_serial_port_tb_top;
   typedef struct packed {
      logic [31:0] a;
      logic w;
      logic [31:0] d;
      logic [31:0] e;
   } row_t;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [31:0] paddr = 32'h0;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready, pslverr, sclk_o, sclk_oe, sdo, sdi, dma_req0, dma_req1, irq;
   logic m_load = 1'b0;
   logic ext_clk = 1'b1;
   logic [7:0] m_byte = 8'h00;
   logic m_lsb = 1'b0;
   logic [7:0] m_rx;
   int mismatches = 0;
   int total_checks = 0;
   int req_n[2] = '{0, 0};
   row_t rows[13];
   always #4 pclk = ~pclk;
   always @(posedge pclk) begin
      if (dma_req0 === 1'b1) req_n[0]++;
      if (dma_req1 === 1'b1) req_n[1]++;
   end
   sync_serial_port dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .sclk_i(ext_clk), .sclk_o(sclk_o), .sclk_oe(sclk_oe), .sdo(sdo),
      .sdi(sdi), .dma_req0(dma_req0), .dma_req1(dma_req1), .irq(irq));
   serial_remote_model remote (.pclk(pclk), .presetn(presetn), .sclk(sclk_o), .sdo(sdo),
      .sdi(sdi), .load(m_load), .tx_byte(m_byte), .lsb_first(m_lsb), .rx_q(m_rx));
   task automatic end_of_test;
      begin
         $display("Counts: %0d checks, %0d mismatches", total_checks, mismatches);
         if (mismatches == 0 && total_checks > 0) begin
            $display("ALL CHECKS OK");
         end else begin
            $display("CHECKS NOT OK");
         end
         $finish;
      end
   endtask : end_of_test
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      begin
         total_checks++;
         if (g !== e) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
         end
      end
   endtask : chk
   task automatic chk_n(input string n, input int e, input int g);
      begin
         total_checks++;
         if (g != e) begin
            mismatches++;
            $display("[FAIL] %s expected %0d seen %0d", n, e, g);
         end
      end
   endtask : chk_n
   task automatic hang(input string n);
      begin
         mismatches++;
         $display("[FAIL] %s expected an answer seen none", n);
         end_of_test();
      end
   endtask : hang
   task automatic cycles(input int n);
      begin
         repeat (n) @(posedge pclk);
      end
   endtask : cycles
   task automatic apb(input logic [31:0] a, input logic w, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
      int n;
      begin
         psel <= 1'b1;
         paddr <= a;
         pwrite <= w;
         pwdata <= d;
         @(posedge pclk);
         penable <= 1'b1;
         n = 0;
         do begin
            @(posedge pclk);
            n++;
         end while (pready !== 1'b1 && n < 16);
         if (pready !== 1'b1) hang("pready");
         r = prdata;
         e = pslverr;
         psel <= 1'b0;
         penable <= 1'b0;
         @(posedge pclk);
      end
   endtask : apb
   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic e;
      begin
         apb(a, 1'b1, d, r, e);
      end
   endtask : wr
   task automatic rd(input string n, input logic [31:0] a, input logic [31:0] x);
      logic [31:0] r;
      logic e;
      begin
         apb(a, 1'b0, 32'h0, r, e);
         chk(n, x, r);
      end
   endtask : rd
   // Selector: 0 and 1 are the two request lines, 2 is the interrupt.
   task automatic wait_hi(input int s, output int c);
      logic v;
      begin
         c = 0;
         do begin
            @(posedge pclk);
            c++;
            v = (s == 0) ? dma_req0 : (s == 1) ? dma_req1 : irq;
         end while (v !== 1'b1 && c < 1000);
         if (v !== 1'b1) hang("wait");
      end
   endtask : wait_hi
   task automatic fall_gap(output int c);
      logic p;
      int s;
      begin
         p = sclk_o;
         c = 0;
         s = 0;
         for (int n = 0; n < 400 && s < 2; n++) begin
            @(posedge pclk);
            if (s == 1) c++;
            if (p === 1'b1 && sclk_o === 1'b0) s++;
            p = sclk_o;
         end
         if (s < 2) hang("clock edge");
      end
   endtask : fall_gap
   task automatic dma_rx(input int ch, input logic [31:0] g, output int sp);
      int t;
      int o;
      begin
         wr(sync_serial_pkg::ADDR_GAP, g);
         wr(sync_serial_pkg::ADDR_GATE, 32'h3 ^ (32'h1 << ch));
         o = req_n[1 - ch];
         wr(sync_serial_pkg::ADDR_CONTROL, 32'ha + ch);
         wait_hi(ch, t);
         wait_hi(ch, sp);
         wr(sync_serial_pkg::ADDR_GATE, 32'h3);
         cycles(4);
         t = req_n[ch];
         cycles(200);
         chk_n("blocked requests", t, req_n[ch]);
         chk_n("other channel", o, req_n[1 - ch]);
         chk("request irq", 32'h1, {31'h0, irq});
         wr(sync_serial_pkg::ADDR_INT_CLEAR, 32'h3);
         $display("test dma channel %0d gap %0d done", ch, g);
      end
   endtask : dma_rx
   initial begin
      int p, s0, s1, s3, n;
      logic [31:0] r;
      logic e;
      rows = '{'{sync_serial_pkg::ADDR_CONTROL, 1'b0, 32'h0, 32'h0},
         '{sync_serial_pkg::ADDR_DATA, 1'b0, 32'h0, 32'h0},
         '{sync_serial_pkg::ADDR_PRESCALER, 1'b0, 32'h0, 32'h0},
         '{sync_serial_pkg::ADDR_GAP, 1'b0, 32'h0, 32'h0},
         '{sync_serial_pkg::ADDR_GATE, 1'b0, 32'h0, 32'h0},
         '{sync_serial_pkg::ADDR_INT_STATUS, 1'b0, 32'h0, 32'h0},
         '{sync_serial_pkg::ADDR_INT_ENABLE, 1'b0, 32'h0, 32'h0},
         '{sync_serial_pkg::ADDR_PRESCALER, 1'b1, 32'hffffffff, 32'hfff},
         '{sync_serial_pkg::ADDR_GAP, 1'b1, 32'h1ff, 32'hff},
         '{sync_serial_pkg::ADDR_GATE, 1'b1, 32'hf, 32'h3},
         '{sync_serial_pkg::ADDR_DATA, 1'b1, 32'h1a5, 32'ha5},
         '{sync_serial_pkg::ADDR_INT_STATUS, 1'b1, 32'h3, 32'h0},
         '{sync_serial_pkg::ADDR_CONTROL, 1'b1, 32'h78, 32'h70}};
      cycles(20);
      presetn <= 1'b1;
      @(posedge pclk);
      foreach (rows[i]) begin
         if (rows[i].w) wr(rows[i].a, rows[i].d);
         rd($sformatf("reg %h", rows[i].a), rows[i].a, rows[i].e);
      end
      n = 0;
      repeat (40) begin
         @(posedge pclk);
         if (sclk_o !== 1'b0) n++;
      end
      chk_n("idle clock", 0, n);
      apb(32'h01d14020, 1'b0, 32'h0, r, e);
      chk("unmapped error", 32'h1, {31'h0, e});
      chk("unmapped data", 32'h0, r);
      $display("test registers done");
      for (int k = 0; k < 2; k++) begin
         wr(sync_serial_pkg::ADDR_PRESCALER, k ? 32'h0 : 32'h2);
         wr(sync_serial_pkg::ADDR_GAP, 32'h0);
         wr(sync_serial_pkg::ADDR_DATA, k ? 32'h01 : 32'ha5);
         wr(sync_serial_pkg::ADDR_INT_ENABLE, 32'h1);
         m_byte <= k ? 8'h80 : 8'h3c;
         m_lsb <= k[0];
         m_load <= 1'b1;
         @(posedge pclk);
         m_load <= 1'b0;
         wr(sync_serial_pkg::ADDR_CONTROL, 32'h29 | (k << 6));
         fall_gap(p);
         chk_n("shift period", k ? 2 : 6, p);
         chk("clock enable", 32'h1, {31'h0, sclk_oe});
         wait_hi(2, p);
         rd("received byte", sync_serial_pkg::ADDR_DATA, k ? 32'h80 : 32'h3c);
         chk("remote byte", k ? 32'h01 : 32'ha5, {24'h0, m_rx});
         rd("done status", sync_serial_pkg::ADDR_INT_STATUS, 32'h1);
         wr(sync_serial_pkg::ADDR_INT_ENABLE, 32'h0);
         cycles(2);
         chk("masked irq", 32'h0, {31'h0, irq});
         wr(sync_serial_pkg::ADDR_INT_ENABLE, 32'h1);
         cycles(2);
         chk("enabled irq", 32'h1, {31'h0, irq});
         wr(sync_serial_pkg::ADDR_INT_CLEAR, 32'h1);
         cycles(2);
         chk("cleared irq", 32'h0, {31'h0, irq});
         rd("cleared status", sync_serial_pkg::ADDR_INT_STATUS, 32'h0);
         $display("test transfer order %0d done", k);
      end
      wr(sync_serial_pkg::ADDR_INT_ENABLE, 32'h2);
      dma_rx(0, 32'h0, s0);
      dma_rx(0, 32'h3, s3);
      chk_n("gap growth", 12, s3 - s0);
      dma_rx(1, 32'h1, s1);
      chk_n("gap growth second channel", 4, s1 - s0);
      wr(sync_serial_pkg::ADDR_DATA, 32'h5a);
      m_byte <= 8'hc3;
      m_lsb <= 1'b0;
      m_load <= 1'b1;
      @(posedge pclk);
      m_load <= 1'b0;
      wr(sync_serial_pkg::ADDR_CONTROL, 32'ha9);
      repeat (16) begin
         ext_clk <= ~ext_clk;
         cycles(2);
      end
      cycles(12);
      chk("external clock enable", 32'h0, {31'h0, sclk_oe});
      rd("external received byte", sync_serial_pkg::ADDR_DATA, 32'hc3);
      chk("external remote byte", 32'h5a, {24'h0, m_rx});
      $display("test external clock done");
      wr(sync_serial_pkg::ADDR_GATE, 32'h2);
      wr(sync_serial_pkg::ADDR_CONTROL, 32'h22);
      wait_hi(0, p);
      wr(sync_serial_pkg::ADDR_DATA, 32'h96);
      wait_hi(0, p);
      chk("dma transmit byte", 32'h96, {24'h0, m_rx});
      wr(sync_serial_pkg::ADDR_GATE, 32'h3);
      $display("test dma transmit done");
      wr(sync_serial_pkg::ADDR_CONTROL, 32'h29);
      cycles(5);
      presetn <= 1'b0;
      cycles(2);
      chk("clock in reset", 32'h1, {31'h0, sclk_o});
      presetn <= 1'b1;
      @(posedge pclk);
      rd("data after reset", sync_serial_pkg::ADDR_DATA, 32'h0);
      rd("gate after reset", sync_serial_pkg::ADDR_GATE, 32'h0);
      $display("test reset in mid transfer done");
      end_of_test();
   end
endmodule : sync_serial_port_tb_top
`default_nettype wire
